/* rtl/bsg_map.svh */
// bsg_map.svh: register selectors, bit positions, reset values and timing counts of the status group
// assumes a 25 MHz system clock; included by the status group, the property checker and the bench
`ifndef BSG_MAP_SVH
`define BSG_MAP_SVH

// ====================================================================
// register selectors (no bus address exists; software names a register by command)
`define BSG_SEL_COND 3'h0
`define BSG_SEL_NEG 3'h1
`define BSG_SEL_POS 3'h2
`define BSG_SEL_EVENT 3'h3
`define BSG_SEL_MASK 3'h4

// ====================================================================
// condition bit positions
`define BSG_BIT_NO_CLOCK 0
`define BSG_BIT_NO_DATA 1
`define BSG_BIT_PRBS_LOSS 2
`define BSG_BIT_UNLOCKED 11
`define BSG_BIT_AMPL 12
`define BSG_BIT_SYNC_LOSS 13
`define BSG_BIT_WAIT_MID 14

// bits that always read zero: 3..10 and 15
`define BSG_COND_USED 16'h78_07

// ====================================================================
// reset values
`define BSG_NEG_RST 16'h0000
`define BSG_POS_RST 16'h7fff
`define BSG_EVENT_RST 16'h0000
`define BSG_MASK_RST 16'h0000

// ====================================================================
// timing
`define BSG_CLK_HZ 25000000
`define BSG_NO_CLOCK_S 3
`define BSG_NO_DATA_EDGES 200

`endif

/* rtl/bsg_pkg.sv */
// bsg_pkg.sv: types shared by the status group
// assumes bsg_map.svh is on the include path
package bsg_pkg;
    typedef logic [15:0] bsg_word_t;
    typedef logic [2:0] bsg_sel_t;
    typedef enum logic [1:0] {
        BSG_SRC_BCAST = 2'h0,
        BSG_SRC_TRAFFIC = 2'h1,
        BSG_SRC_PACKET = 2'h3
    } bsg_src_t;
endpackage

/* rtl/bsg_status_group.sv */
// bsg_status_group.sv: status register group of a bit-error-rate tester
// assumes the command parser issues one-cycle read/write strobes on the system clock
// Functional notes
// [R1] no tester clock for over 3 s
// [R2] data unchanged over last 200 tester clocks
// [R3] prbs sync loss while not synchronized
// [R4] bits 3 to 10 and 15 read zero
// [R5] demodulator or down converter out of lock
// [R6] demodulator amplitude outside permitted range
// [R7] sync loss of the selected source
// [R8] waiting for midamble; follows bit 13 or loss
// [R9] instrument reset clears bits 2, 12-14
// [R10] condition register live and read only
// [R11] per-bit positive and negative transition filters
// [R12] selected transitions set sticky event bits
// [R13] event read returns contents then clears all
// [R14] summary bit drives parent questionable bit
// [R15] summary is OR of event AND mask
`timescale 1ns/1ns
`include "bsg_map.svh"

module bsg_status_group #(
    parameter int CLK_HZ = `BSG_CLK_HZ,
    parameter int NO_CLOCK_CYCLES = `BSG_NO_CLOCK_S * CLK_HZ,
    parameter int NO_DATA_EDGES = `BSG_NO_DATA_EDGES
) (
    input wire logic clock, // system clock, 25 MHz
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic inst_reset, // instrument reset command, one-cycle pulse
    input wire logic tester_clk, // tester clock pin, asynchronous
    input wire logic tester_data, // tester data pin, asynchronous
    input wire logic prbs_locked, // prbs synchronizer locked, asynchronous
    input wire logic demod_locked, // demodulator in lock, asynchronous
    input wire logic dnconv_locked, // down converter in lock, asynchronous
    input wire logic ampl_in_range, // demodulator amplitude in range, asynchronous
    input wire logic bcast_synced, // broadcast channel synced, asynchronous
    input wire logic traffic_synced, // traffic channel synced, asynchronous
    input wire logic packet_synced, // packet data channel synced, asynchronous
    input wire logic midamble_seen, // traffic/packet midamble received, asynchronous
    input wire bsg_pkg::bsg_src_t sync_source, // selected sync source, same domain
    input wire bsg_pkg::bsg_sel_t reg_sel, // register selector
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic reg_rd, // read strobe, one cycle
    input wire bsg_pkg::bsg_word_t reg_wdata, // write data
    output bsg_pkg::bsg_word_t reg_rdata, // read data, registered
    output logic reg_rvalid, // read data valid, one cycle
    output logic summary_bit // summary to parent questionable register
);
    import bsg_pkg::*;

    // ====================================================================
    // pin synchronizers: stage one feeds stage two only
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    assign pin_raw = {tester_clk, tester_data, prbs_locked, demod_locked, dnconv_locked,
                      ampl_in_range, bcast_synced, traffic_synced, packet_synced, midamble_seen};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    wire s_tclk = sync2_q[9];
    wire s_data = sync2_q[8];
    wire s_prbs = sync2_q[7];
    wire s_demod = sync2_q[6];
    wire s_dnconv = sync2_q[5];
    wire s_ampl = sync2_q[4];
    wire s_bcast = sync2_q[3];
    wire s_traffic = sync2_q[2];
    wire s_packet = sync2_q[1];
    wire s_mid = sync2_q[0];

    // ====================================================================
    // tester clock edge and data change detection
    logic tclk_prev_q;
    logic data_prev_q;
    wire tclk_rise = s_tclk & ~tclk_prev_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tclk_prev_q <= 1'b0;
            data_prev_q <= 1'b0;
        end else begin
            tclk_prev_q <= s_tclk;
            data_prev_q <= s_data;
        end
    end

    // ====================================================================
    // no-clock timer: counts system cycles since the last tester clock rise
    localparam int NCW = $clog2(NO_CLOCK_CYCLES + 2);
    localparam logic [NCW-1:0] NC_LIMIT = NCW'(NO_CLOCK_CYCLES);
    logic [NCW-1:0] nclk_cnt_q;
    logic [NCW-1:0] nclk_cnt_d;
    wire nclk_over = (nclk_cnt_q > NC_LIMIT); // R1
    assign nclk_cnt_d = tclk_rise ? '0 : (nclk_over ? nclk_cnt_q : nclk_cnt_q + NCW'(1));

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            nclk_cnt_q <= '0;
        end else begin
            nclk_cnt_q <= nclk_cnt_d; // R1
        end
    end

    // ====================================================================
    // no-data-change counter: tester clock rises since data last differed
    localparam int NDW = $clog2(NO_DATA_EDGES + 1);
    localparam logic [NDW-1:0] ND_LIMIT = NDW'(NO_DATA_EDGES);
    logic [NDW-1:0] ndat_cnt_q;
    logic [NDW-1:0] ndat_cnt_d;
    logic data_changed_q;
    wire ndat_full = (ndat_cnt_q >= ND_LIMIT); // R2
    // a change between two edges is remembered until the next edge counts it
    wire data_seen_change = data_changed_q | (s_data != data_prev_q);
    assign ndat_cnt_d = !tclk_rise ? ndat_cnt_q :
                        (data_seen_change ? '0 : (ndat_full ? ndat_cnt_q : ndat_cnt_q + NDW'(1)));

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ndat_cnt_q <= '0;
            data_changed_q <= 1'b0;
        end else begin
            ndat_cnt_q <= ndat_cnt_d; // R2
            data_changed_q <= tclk_rise ? 1'b0 : data_seen_change;
        end
    end

    // ====================================================================
    // registered flags cleared by instrument reset
    // the reset clears them, but a still-present fault sets them again next cycle
    logic prbs_loss_q;
    logic ampl_bad_q;
    logic sync_loss_q;
    logic wait_mid_q;
    logic chan_was_synced_q;

    wire sel_synced = (sync_source == BSG_SRC_BCAST) ? s_bcast :
                      (sync_source == BSG_SRC_TRAFFIC) ? s_traffic : s_packet; // R7
    wire chan_synced = (sync_source == BSG_SRC_PACKET) ? s_packet : s_traffic;
    wire chan_lost = chan_was_synced_q & ~chan_synced & ~s_mid; // R8

    always_ff @(posedge clock) begin
        if (sys_rst | inst_reset) begin
            prbs_loss_q <= 1'b0; // R9
            ampl_bad_q <= 1'b0; // R9
            sync_loss_q <= 1'b0; // R9
            wait_mid_q <= 1'b0; // R9
            chan_was_synced_q <= 1'b0;
        end else begin
            prbs_loss_q <= ~s_prbs; // R3
            ampl_bad_q <= ~s_ampl; // R6
            sync_loss_q <= ~sel_synced; // R7
            wait_mid_q <= ~sel_synced | chan_lost | ~s_mid; // R8
            chan_was_synced_q <= chan_was_synced_q | chan_synced;
        end
    end

    // ====================================================================
    // live condition word
    bsg_word_t cond_w;
    always_comb begin
        cond_w = '0; // R4
        cond_w[`BSG_BIT_NO_CLOCK] = nclk_over; // R1
        cond_w[`BSG_BIT_NO_DATA] = ndat_full; // R2
        cond_w[`BSG_BIT_PRBS_LOSS] = prbs_loss_q; // R3
        cond_w[`BSG_BIT_UNLOCKED] = ~s_demod | ~s_dnconv; // R5
        cond_w[`BSG_BIT_AMPL] = ampl_bad_q; // R6
        cond_w[`BSG_BIT_SYNC_LOSS] = sync_loss_q; // R7
        cond_w[`BSG_BIT_WAIT_MID] = wait_mid_q | sync_loss_q; // R8
    end
    wire [15:0] cond_live = cond_w & `BSG_COND_USED; // R4

    // ====================================================================
    // filters, event latch and mask
    bsg_word_t cond_prev_q;
    bsg_word_t neg_q;
    bsg_word_t pos_q;
    bsg_word_t event_q;
    bsg_word_t event_d;
    bsg_word_t mask_q;

    wire wr_neg = reg_wr & (reg_sel == `BSG_SEL_NEG);
    wire wr_pos = reg_wr & (reg_sel == `BSG_SEL_POS);
    wire wr_mask = reg_wr & (reg_sel == `BSG_SEL_MASK);
    wire rd_event = reg_rd & (reg_sel == `BSG_SEL_EVENT);

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_evt
            wire rise = cond_live[gi] & ~cond_prev_q[gi];
            wire fall = ~cond_live[gi] & cond_prev_q[gi];
            wire hit = (rise & pos_q[gi]) | (fall & neg_q[gi]); // R11
            // a hit in the read cycle survives the clear
            assign event_d[gi] = hit | (event_q[gi] & ~rd_event); // R12 R13
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cond_prev_q <= '0;
            neg_q <= `BSG_NEG_RST;
            pos_q <= `BSG_POS_RST;
            event_q <= `BSG_EVENT_RST;
            mask_q <= `BSG_MASK_RST;
        end else begin
            cond_prev_q <= cond_live;
            event_q <= event_d; // R12
            if (wr_neg) neg_q <= reg_wdata; // R11
            if (wr_pos) pos_q <= reg_wdata; // R11
            if (wr_mask) mask_q <= reg_wdata;
        end
    end

    assign summary_bit = |(event_q & mask_q); // R14 R15

    // ====================================================================
    // read port; writes to the condition and event selectors are dropped
    bsg_word_t rd_mux;
    always_comb begin
        case (reg_sel)
            `BSG_SEL_COND: rd_mux = cond_live; // R10
            `BSG_SEL_NEG: rd_mux = neg_q;
            `BSG_SEL_POS: rd_mux = pos_q;
            `BSG_SEL_EVENT: rd_mux = event_q; // R13
            `BSG_SEL_MASK: rd_mux = mask_q;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) reg_rdata <= rd_mux;
        end
    end

endmodule // bsg_status_group

/* tb/bsg_status_group_properties.sv */
// bsg_status_group_properties.sv: port-level assertions for the status group
// assumes bsg_map.svh on the include path; bound to the design from the bench top file
`timescale 1ns/1ns
`include "bsg_map.svh"

module bsg_status_group_properties #(
    parameter int NO_CLOCK_CYCLES = 50
) (
    input wire logic clock, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic tester_clk, // tester clock pin
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire bsg_pkg::bsg_sel_t reg_sel, // register selector
    input wire bsg_pkg::bsg_word_t reg_wdata, // write data
    input wire bsg_pkg::bsg_word_t reg_rdata, // read data
    input wire logic reg_rvalid, // read data valid
    input wire logic summary_bit // summary output
);
    import bsg_pkg::*;
    int unsigned idle_q;
    logic tclk_q;

    // ======================================
    // cycles since the last tester clock rise; margins cover the pin synchronizer
    always_ff @(posedge clock) begin
        tclk_q <= tester_clk;
        if (sys_rst || (tester_clk && !tclk_q)) begin
            idle_q <= 0;
        end else begin
            idle_q <= idle_q + 1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // ======================================
    // properties
    sequence rd_cond_s;
        reg_rd && reg_sel == `BSG_SEL_COND;
    endsequence
    sequence cfg_wr_rd_s;
        (reg_wr && (reg_sel == `BSG_SEL_NEG || reg_sel == `BSG_SEL_POS || reg_sel == `BSG_SEL_MASK))
            ##2 (reg_rd && reg_sel == $past(reg_sel, 2));
    endsequence

    a_read_answered: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("valid without read");
    a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data moved");
    a_cfg_readback: assert property (cfg_wr_rd_s |=> reg_rdata == $past(reg_wdata, 3)) else $error("readback");
    a_cond_unused: assert property (rd_cond_s |=> (reg_rdata & ~`BSG_COND_USED) == 16'h0000)
        else $error("unused condition bit set");
    a_unmapped_zero: assert property (reg_rd && reg_sel > 3'h4 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_mask_off: assert property (reg_wr && reg_sel == `BSG_SEL_MASK && reg_wdata == 16'h0000 |=> !summary_bit)
        else $error("summary with empty mask");
    a_noclk_set: assert property (rd_cond_s ##0 (idle_q > NO_CLOCK_CYCLES + 6) |=> reg_rdata[0])
        else $error("no clock not flagged");
    a_noclk_clear: assert property (rd_cond_s ##0 (idle_q + 10 < NO_CLOCK_CYCLES &&
        $past(idle_q, 4) + 10 < NO_CLOCK_CYCLES) |=> !reg_rdata[0]) else $error("no clock flagged early");
endmodule // bsg_status_group_properties

/* tb/bsg_status_group_tb.sv */
// bsg_status_group_tb.sv: self-checking bench for the status group
// assumes the rtl package, map header and property checker are compiled first
`timescale 1ns/1ns
`include "bsg_map.svh"

module bsg_status_group_tb;
    import bsg_pkg::*;
    localparam bsg_sel_t COND = `BSG_SEL_COND, NEG = `BSG_SEL_NEG, POS = `BSG_SEL_POS;
    localparam bsg_sel_t EVT = `BSG_SEL_EVENT, MSK = `BSG_SEL_MASK;
    logic clock = 0, sys_rst = 1, inst_reset = 0, tester_clk = 0, tester_data = 0, half = 0;
    logic clk_run = 1, data_run = 1, reg_wr = 0, reg_rd = 0, reg_rvalid, summary_bit;
    logic [7:0] st = 8'hff; // prbs, demod, dnconv, ampl, bcast, traffic, packet, midamble
    // status inputs, source, expected condition word
    logic [25:0] rows [10] = '{{8'hff, 2'h0, 16'h0000}, {8'h7f, 2'h0, 16'h0004}, {8'hbf, 2'h0, 16'h0800},
        {8'hcf, 2'h0, 16'h1800}, {8'hf7, 2'h0, 16'h6000}, {8'hf3, 2'h1, 16'h6000}, {8'hf1, 2'h3, 16'h6000},
        {8'hf3, 2'h3, 16'h0000}, {8'hfe, 2'h0, 16'h4000}, {8'h00, 2'h1, 16'h7804}};
    bsg_src_t sync_source = BSG_SRC_BCAST;
    bsg_sel_t reg_sel = 3'h0;
    bsg_word_t reg_wdata = 16'h0000, reg_rdata, got, prev = 16'h0000;
    int num_errors = 0, checks_done = 0;

    // ======================================
    // design and clocks
    bsg_status_group #(.NO_CLOCK_CYCLES(50), .NO_DATA_EDGES(8)) bsg_status_group_i (
        .clock(clock), .sys_rst(sys_rst), .inst_reset(inst_reset), .tester_clk(tester_clk), .tester_data(tester_data),
        .prbs_locked(st[7]), .demod_locked(st[6]), .dnconv_locked(st[5]), .ampl_in_range(st[4]), .bcast_synced(st[3]),
        .traffic_synced(st[2]), .packet_synced(st[1]), .midamble_seen(st[0]), .sync_source(sync_source),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .summary_bit(summary_bit));

    initial forever #20 clock = ~clock;

    // tester clock at a quarter of the system rate; data flips on each rise
    always @(posedge clock) begin
        half <= ~half;
        if (clk_run && half) begin
            tester_clk <= ~tester_clk;
            if (data_run && !tester_clk) tester_data <= ~tester_data;
        end
    end

    // ======================================
    // helpers
    task automatic check(input bsg_word_t seen, input bsg_word_t exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input bsg_sel_t sel, input bsg_word_t d);
        @(posedge clock);
        reg_wr <= 1;
        reg_sel <= sel;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 0;
    endtask
    task automatic rd(input bsg_sel_t sel, output bsg_word_t d);
        @(posedge clock);
        reg_rd <= 1;
        reg_sel <= sel;
        @(posedge clock);
        reg_rd <= 0;
        #1;
        d = reg_rdata;
    endtask
    task automatic rchk(input bsg_sel_t sel, input bsg_word_t exp);
        rd(sel, got);
        check(got, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic give_verdict;
        $display("checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        settle(3000);
        num_errors++;
        give_verdict();
    end

    // ======================================
    // tests
    initial begin
        settle(20);
        sys_rst <= 0;
        rchk(NEG, `BSG_NEG_RST);
        rchk(POS, `BSG_POS_RST);
        rchk(MSK, `BSG_MASK_RST);
        wr(POS, 16'hffff);
        wr(NEG, 16'hffff);
        wr(MSK, 16'hffff);
        rchk(MSK, 16'hffff);
        settle(8);
        rd(EVT, got);
        foreach (rows[i]) begin
            @(posedge clock);
            st <= rows[i][25:18];
            settle(3);
            sync_source <= bsg_src_t'(rows[i][17:16]);
            settle(6);
            rchk(COND, rows[i][15:0]);
            check({15'h0, summary_bit}, {15'h0, rows[i][15:0] != prev});
            rchk(EVT, rows[i][15:0] ^ prev);
            check({15'h0, summary_bit}, 16'h0000);
            prev = rows[i][15:0];
        end
        @(posedge clock);
        inst_reset <= 1;
        @(posedge clock);
        inst_reset <= 0;
        reg_rd <= 1;
        reg_sel <= COND;
        @(posedge clock);
        reg_rd <= 0;
        #1;
        check(reg_rdata, 16'h0800);
        @(posedge clock);
        st <= 8'hff;
        sync_source <= BSG_SRC_BCAST;
        settle(8);
        rd(EVT, got);
        rchk(EVT, 16'h0000);
        wr(POS, 16'h0000);
        wr(NEG, 16'h0004);
        @(posedge clock);
        st <= 8'h7f;
        settle(8);
        rchk(EVT, 16'h0000);
        st <= 8'hff;
        settle(8);
        check({15'h0, summary_bit}, 16'h0001);
        rchk(EVT, 16'h0004);
        wr(EVT, 16'hffff);
        wr(COND, 16'hffff);
        rchk(EVT, 16'h0000);
        rchk(COND, 16'h0000);
        rchk(3'h5, 16'h0000);
        @(posedge clock);
        clk_run <= 0;
        settle(70);
        rd(COND, got);
        check({15'h0, got[0]}, 16'h0001);
        clk_run <= 1;
        settle(16);
        rd(COND, got);
        check({15'h0, got[0]}, 16'h0000);
        data_run <= 0;
        settle(60);
        rd(COND, got);
        check({15'h0, got[1]}, 16'h0001);
        data_run <= 1;
        settle(16);
        rd(COND, got);
        check({15'h0, got[1]}, 16'h0000);
        wr(MSK, 16'h0000);
        #1;
        check({15'h0, summary_bit}, 16'h0000);
        give_verdict();
    end
endmodule // bsg_status_group_tb

bind bsg_status_group bsg_status_group_properties #(.NO_CLOCK_CYCLES(NO_CLOCK_CYCLES)) bsg_status_group_properties_i (
    .clock(clock), .sys_rst(sys_rst), .tester_clk(tester_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .summary_bit(summary_bit));
